// *** inc/ssi_map.vh ***
// Constants for the management-side status and interrupt pin block.
`ifndef SSI_MAP_VH
`define SSI_MAP_VH
// Register index carried in the command byte.
`define SSI_IDX_COMMON 8'h00
`define SSI_IDX_STAT_A 8'h01
`define SSI_IDX_STAT_B 8'h02
// Common status field positions.
`define SSI_CS_MASK_BIT 3
`define SSI_CS_GPI_A_BIT 4
`define SSI_CS_GPI_B_BIT 5
// Per-slot status field positions.
`define SSI_ST_OVERCURRENT_BIT 0
`define SSI_ST_UNDERVOLT_BIT 1
`define SSI_ST_OVERTEMP_BIT 2
// Reset values.
`define SSI_CS_MASK_RESET 1'b0
`define SSI_STAT_RESET 3'h0
// Upper four bits of the seven-bit bus address; the straps give the low three.
`define SSI_ADDR_BASE 4'h8
// Slot index of the last data bit of a byte and slot index of the acknowledge slot.
`define SSI_BYTE_LAST 4'h7
`define SSI_ACK_SLOT 4'h8
`endif

// *** src/ssi_bit_engine.v ***
// Byte-level shifter for the two-wire management bus, slave side.
`timescale 1ns/1ns
`include "ssi_map.vh"
module ssi_bit_engine (
    input wire clk,
    input wire nrst,
    input wire scl_in,
    input wire sda_in,
    input wire ack_en,
    input wire tx_mode,
    input wire [7:0] tx_byte,
    output reg start_p,
    output reg stop_p,
    output reg rx_valid,
    output reg [7:0] rx_byte,
    output reg mack_p,
    output reg mack_ok,
    output reg sda_oe
);
    reg scl_q; // Sampled clock line.
    reg sda_q; // Sampled data line.
    reg scl_prev; // Clock line one cycle earlier.
    reg sda_prev; // Data line one cycle earlier.
    reg active_reg; // High between a start and a stop.
    reg tx_lat_reg; // Direction of the byte now on the wire.
    reg [3:0] cnt_reg; // Bit slot within the byte, 8 is the acknowledge slot.
    reg [7:0] sh_reg; // Receive shift register.
    wire scl_rise; // Rising clock edge.
    wire scl_fall; // Falling clock edge.
    wire [3:0] cnt_next; // Slot that follows a falling edge.

    assign scl_rise = scl_q & ~scl_prev;
    assign scl_fall = ~scl_q & scl_prev;
    assign cnt_next = (cnt_reg == `SSI_ACK_SLOT) ? 4'h0 : cnt_reg + 4'h1;

    // Samples both lines and keeps the previous values for edge detection.
    always @(posedge clk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_prev <= scl_q;
            sda_prev <= sda_q;
        end
    end

    // Tracks bit slots, shifts data in, and drives the data line low when needed.
    always @(posedge clk) begin
        if (!nrst) begin
            start_p <= 1'b0;
            stop_p <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            mack_p <= 1'b0;
            mack_ok <= 1'b0;
            sda_oe <= 1'b0;
            active_reg <= 1'b0;
            tx_lat_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
        end else begin
            start_p <= 1'b0;
            stop_p <= 1'b0;
            rx_valid <= 1'b0;
            mack_p <= 1'b0;
            if (scl_q && scl_prev && sda_prev && !sda_q) begin
                // Start or repeated start: a new address byte follows.
                // The slot counter parks on the acknowledge slot.
                // The first clock fall after the start then opens bit slot 0.
                // Without this the first fall would skip a slot and lose the MSB.
                start_p <= 1'b1;
                active_reg <= 1'b1;
                tx_lat_reg <= 1'b0;
                cnt_reg <= `SSI_ACK_SLOT;
                sda_oe <= 1'b0;
            end else if (scl_q && scl_prev && !sda_prev && sda_q) begin
                // Stop: release the line and go idle.
                stop_p <= 1'b1;
                active_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else if (active_reg && scl_rise) begin
                if (cnt_reg == `SSI_ACK_SLOT) begin
                    // Host acknowledge after a byte that this block sent.
                    if (tx_lat_reg) begin
                        mack_p <= 1'b1;
                        mack_ok <= ~sda_q;
                    end
                end else begin
                    sh_reg <= {sh_reg[6:0], sda_q};
                    if (cnt_reg == `SSI_BYTE_LAST && !tx_lat_reg) begin
                        rx_valid <= 1'b1;
                        rx_byte <= {sh_reg[6:0], sda_q};
                    end
                end
            end else if (active_reg && scl_fall) begin
                cnt_reg <= cnt_next;
                if (cnt_next == 4'h0) begin
                    // A new byte starts; its direction is fixed here.
                    tx_lat_reg <= tx_mode;
                    sda_oe <= tx_mode & ~tx_byte[7];
                end else if (cnt_next == `SSI_ACK_SLOT) begin
                    // Acknowledge a received byte when the owner accepts it.
                    sda_oe <= ~tx_lat_reg & ack_en;
                end else begin
                    sda_oe <= tx_lat_reg & ~tx_byte[3'd7 - cnt_next[2:0]];
                end
            end
        end
    end
endmodule

// *** src/ssi_status_irq.v ***
// Status pins, strap address, fault flags and interrupt line of the hot-plug controller.
`timescale 1ns/1ns
`include "ssi_map.vh"
// How it works
// (R1) Two general inputs show in common status bits 4,5.
// (R2) Three straps set the bus address low bits.
// (R3) Unmasked fault pulls interrupt line low.
// (R4) Interrupt holds until host echo-clears fault bits. The code also releases it when the host sets the mask bit.
// (R5) Data pin two-way, clock pin input only.
// (R6) Fault means overcurrent, undervoltage or overtemperature trip.
// (R7) Writing one clears that fault bit only.
module ssi_status_irq (
    input wire clk,
    input wire nrst,
    input wire general_input_slot_a,
    input wire general_input_slot_b,
    input wire addr_strap_bit2,
    input wire addr_strap_bit1,
    input wire addr_strap_bit0,
    input wire [2:0] trip_slot_a,
    input wire [2:0] trip_slot_b,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg int_n_out,
    output reg int_n_oe
);
    // Transaction states.
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CMD = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_READ = 3'h4;
    localparam ST_SKIP = 3'h5;

    reg [2:0] state_reg; // Transaction state.
    reg [2:0] state_next; // Next transaction state.
    reg [2:0] strap_reg; // Address straps caught while reset is held.
    reg [7:0] ptr_reg; // Register index from the command byte.
    reg [7:0] ptr_next; // Next register index.
    reg ack_reg; // Accept the byte now being received.
    reg ack_next; // Next accept decision.
    reg tx_reg; // Send data in the next byte.
    reg tx_next; // Next send decision.
    reg [7:0] rd_reg; // Byte offered to the host on a read.
    reg mask_reg; // Interrupt mask, high blocks the line.
    reg mask_next; // Next interrupt mask.
    reg [1:0] gpi_reg; // Sampled general inputs.
    reg [2:0] stat_a_reg; // Sticky fault flags of slot A.
    reg [2:0] stat_a_next; // Next fault flags of slot A.
    reg [2:0] stat_b_reg; // Sticky fault flags of slot B.
    reg [2:0] stat_b_next; // Next fault flags of slot B.
    reg [2:0] clr_a; // Echo-clear bits for slot A this cycle.
    reg [2:0] clr_b; // Echo-clear bits for slot B this cycle.
    reg [7:0] cs_view; // Common status as read.

    wire start_p; // Start condition seen.
    wire stop_p; // Stop condition seen.
    wire rx_valid; // A received byte is ready.
    wire [7:0] rx_byte; // The received byte.
    wire mack_p; // Host acknowledge slot seen.
    wire mack_ok; // Host acknowledged the sent byte.
    wire eng_oe; // Engine wants the data line low.
    wire [6:0] my_addr; // This device's seven-bit address.

    // Bus address: fixed high bits, strap low bits; an open strap reads high.
    assign my_addr = {`SSI_ADDR_BASE, strap_reg}; // [R2]

    // Shifter that owns the bit timing; the clock pin is only ever read.
    ssi_bit_engine u_engine (
        .clk(clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ack_en(ack_reg),
        .tx_mode(tx_reg),
        .tx_byte(rd_reg),
        .start_p(start_p),
        .stop_p(stop_p),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .mack_p(mack_p),
        .mack_ok(mack_ok),
        .sda_oe(eng_oe)
    ); // [R5]

    // Builds the common status byte from the mask and the input pins.
    always @* begin
        cs_view = 8'h00;
        cs_view[`SSI_CS_MASK_BIT] = mask_reg;
        cs_view[`SSI_CS_GPI_A_BIT] = gpi_reg[0]; // [R1]
        cs_view[`SSI_CS_GPI_B_BIT] = gpi_reg[1]; // [R1]
    end

    // Walks through address, command and data bytes and decides each acknowledge.
    always @* begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        ack_next = ack_reg;
        tx_next = tx_reg;
        mask_next = mask_reg;
        clr_a = 3'h0;
        clr_b = 3'h0;
        if (start_p) begin
            // Every start, repeated or not, expects an address byte.
            state_next = ST_ADDR;
            ack_next = 1'b0;
            tx_next = 1'b0;
        end else if (stop_p) begin
            // The transfer ends; nothing more is sent or accepted.
            state_next = ST_IDLE;
            ack_next = 1'b0;
            tx_next = 1'b0;
        end else if (rx_valid) begin
            case (state_reg)
                ST_ADDR: begin
                    if (rx_byte[7:1] == my_addr) begin
                        // Our address: a read sends, a write expects a command.
                        ack_next = 1'b1;
                        tx_next = rx_byte[0];
                        state_next = rx_byte[0] ? ST_READ : ST_CMD;
                    end else begin
                        // Another device is addressed; stay silent.
                        ack_next = 1'b0;
                        state_next = ST_SKIP;
                    end
                end
                ST_CMD: begin
                    // The command byte selects the register.
                    ptr_next = rx_byte;
                    ack_next = 1'b1;
                    state_next = ST_DATA;
                end
                ST_DATA: begin
                    // Data byte: the mask is stored, fault bits are echo-cleared.
                    ack_next = 1'b1;
                    if (ptr_reg == `SSI_IDX_COMMON) begin
                        mask_next = rx_byte[`SSI_CS_MASK_BIT];
                    end else if (ptr_reg == `SSI_IDX_STAT_A) begin
                        clr_a = rx_byte[2:0]; // [R7]
                    end else if (ptr_reg == `SSI_IDX_STAT_B) begin
                        clr_b = rx_byte[2:0]; // [R7]
                    end
                end
                default: begin
                    // Bytes outside a transfer to us are refused.
                    ack_next = 1'b0;
                end
            endcase
        end else if (mack_p && state_reg == ST_READ) begin
            // A host not-acknowledge ends the read; otherwise the byte repeats.
            if (!mack_ok) begin
                tx_next = 1'b0;
                state_next = ST_SKIP;
            end
        end
    end

    // Sticky faults: a trip sets a flag, only an echoed one clears it, and a set wins.
    always @* begin
        stat_a_next = (stat_a_reg & ~clr_a) | trip_slot_a; // [R6] [R7]
        stat_b_next = (stat_b_reg & ~clr_b) | trip_slot_b; // [R6] [R7]
    end

    // Read data for the next byte sent to the host.
    always @(posedge clk) begin
        if (!nrst) begin
            rd_reg <= 8'h00;
        end else if (ptr_reg == `SSI_IDX_COMMON) begin
            rd_reg <= cs_view;
        end else if (ptr_reg == `SSI_IDX_STAT_A) begin
            rd_reg <= {5'h00, stat_a_reg};
        end else if (ptr_reg == `SSI_IDX_STAT_B) begin
            rd_reg <= {5'h00, stat_b_reg};
        end else begin
            rd_reg <= 8'h00;
        end
    end

    // Catches the straps while reset is held; they stay fixed afterwards.
    always @(posedge clk) begin
        if (!nrst) begin
            strap_reg <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}; // [R2]
        end
    end

    // Control state, fault flags and the sampled general inputs.
    always @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            ptr_reg <= 8'h00;
            ack_reg <= 1'b0;
            tx_reg <= 1'b0;
            mask_reg <= `SSI_CS_MASK_RESET;
            gpi_reg <= 2'h0;
            stat_a_reg <= `SSI_STAT_RESET;
            stat_b_reg <= `SSI_STAT_RESET;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            ack_reg <= ack_next;
            tx_reg <= tx_next;
            mask_reg <= mask_next;
            gpi_reg <= {general_input_slot_b, general_input_slot_a}; // [R1]
            stat_a_reg <= stat_a_next;
            stat_b_reg <= stat_b_next;
        end
    end

    // Pins: both are open drain, so the driven level is always low.
    always @(posedge clk) begin
        if (!nrst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            int_n_out <= 1'b0;
            int_n_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= eng_oe; // [R5]
            int_n_out <= 1'b0;
            // Low while any flag stands and the mask is clear; release follows the echo-clear.
            int_n_oe <= (|stat_a_next | |stat_b_next) & ~mask_next; // [R3] [R4]
        end
    end
endmodule

// *** verification/ssi_status_irq_sva.sv ***
// Assertion checker for the status pin and interrupt block.
`timescale 1ns/1ns
module ssi_status_irq_sva (
    input wire clk,
    input wire nrst,
    input wire general_input_slot_a,
    input wire general_input_slot_b,
    input wire addr_strap_bit2,
    input wire addr_strap_bit1,
    input wire addr_strap_bit0,
    input wire [2:0] trip_slot_a,
    input wire [2:0] trip_slot_b,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire int_n_out,
    input wire int_n_oe
);
    // Recent bus clock samples, newest in bit 0.
    reg [5:0] scl_hist_reg;
    // Set once the bus clock has gone low since reset.
    reg bus_seen_reg;
    // A clock rise two to five cycles back, when register writes land.
    wire [3:0] rise_seen = scl_hist_reg[4:1] & ~scl_hist_reg[5:2];
    wire bus_step = |rise_seen;
    // Keeps the history and notes the first bus activity.
    always @(posedge clk) begin
        scl_hist_reg <= {scl_hist_reg[4:0], scl_in};
        if (!nrst) begin
            bus_seen_reg <= 1'b0;
        end else if (!scl_in) begin
            bus_seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // The bus clock has just fallen.
    sequence s_scl_fall;
        !scl_in && $past(scl_in);
    endsequence
    property p_sda_out_low;
        sda_out == 1'b0;
    endproperty
    property p_int_out_low;
        int_n_out == 1'b0;
    endproperty
    property p_reset_quiet;
        $rose(nrst) |-> !sda_oe && !int_n_oe;
    endproperty
    property p_oe_hold;
        s_scl_fall |-> $stable(sda_oe)[*2];
    endproperty
    property p_oe_change;
        $changed(sda_oe) |-> !scl_in && !$past(scl_in);
    endproperty
    property p_int_rise;
        $rose(int_n_oe) |-> $past(|{trip_slot_a, trip_slot_b}) || bus_step;
    endproperty
    property p_int_release;
        $fell(int_n_oe) |-> bus_step;
    endproperty
    property p_first_trip;
        !bus_seen_reg && |{trip_slot_a, trip_slot_b} |=> int_n_oe;
    endproperty
    a_sda_out_low: assert property (p_sda_out_low) else $error("data output not low");
    a_int_out_low: assert property (p_int_out_low) else $error("interrupt output not low");
    a_reset_quiet: assert property (p_reset_quiet) else $error("line driven after reset");
    a_oe_hold: assert property (p_oe_hold) else $error("data drive changed near clock fall");
    a_oe_change: assert property (p_oe_change) else $error("data drive changed while clock high");
    a_int_rise: assert property (p_int_rise) else $error("interrupt without cause");
    a_int_release: assert property (p_int_release) else $error("interrupt released without write");
    a_first_trip: assert property (p_first_trip) else $error("unmasked trip gave no interrupt");
endmodule
bind ssi_status_irq ssi_status_irq_sva i_sva (.clk(clk), .nrst(nrst),
    .general_input_slot_a(general_input_slot_a), .general_input_slot_b(general_input_slot_b),
    .addr_strap_bit2(addr_strap_bit2), .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit0(addr_strap_bit0),
    .trip_slot_a(trip_slot_a), .trip_slot_b(trip_slot_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));

// *** verification/ssi_host_model.sv ***
// Bus master model that clocks the link and shares the data line.
`timescale 1ns/1ns
module ssi_host_model (
    input wire clk,
    input wire dut_pull,
    output reg scl,
    output wire sda
);
    // High while the host pulls the data line low.
    reg host_pull = 1'b0;
    // Open-drain line with pull-up, low when either side pulls.
    assign sda = !(host_pull || dut_pull);
    // The host supplies the clock and holds it high when idle.
    initial begin
        scl = 1'b1;
    end
    // Waits n clocks and steps just past the edge.
    task w(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // One bus bit: data set mid low phase, sampled mid high phase.
    task bit_io(input b, output r);
        begin
            scl = 1'b0;
            w(2);
            host_pull = !b;
            w(3);
            scl = 1'b1;
            w(2);
            r = sda;
            w(3);
        end
    endtask
    // Start uses pulls 0 then 1; stop uses 1 then 0.
    task edge_cond(input first, input last);
        begin
            scl = 1'b0;
            w(2);
            host_pull = first;
            w(3);
            scl = 1'b1;
            w(5);
            host_pull = last;
            w(5);
        end
    endtask
    // Eight bits out MSB first plus the acknowledge slot.
    task xfer(input [7:0] d, input a_in, output [7:0] q, output a_out);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(d[i], q[i]);
            end
            bit_io(a_in, a_out);
        end
    endtask
endmodule

// *** verification/ssi_status_irq_tb.sv ***
// Self-checking bench for the status pin and interrupt block.
`timescale 1ns/1ns
`include "ssi_map.vh"
module ssi_status_irq_tb;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg gpa = 1'b0;
    reg gpb = 1'b0;
    reg [2:0] strap = 3'h7;
    reg [2:0] trip_a = 3'h0;
    reg [2:0] trip_b = 3'h0;
    reg [2:0] oh;
    reg [7:0] q;
    reg [7:0] idx;
    reg ack;
    integer s;
    integer n_errors = 0;
    integer n_checks = 0;
    wire scl;
    wire sda;
    wire sda_out;
    wire sda_oe;
    wire int_n_out;
    wire int_n_oe;
    // Own and foreign bus addresses.
    wire [6:0] dev = {`SSI_ADDR_BASE, strap};
    wire [6:0] bad = {`SSI_ADDR_BASE, strap ^ 3'h1};
    always #50 clk = !clk;
    ssi_status_irq i_dut (.clk(clk), .nrst(nrst), .general_input_slot_a(gpa), .general_input_slot_b(gpb),
        .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]),
        .trip_slot_a(trip_a), .trip_slot_b(trip_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    ssi_host_model i_host (.clk(clk), .dut_pull(sda_oe), .scl(scl), .sda(sda));
    // Expected common status for a given mask.
    function [7:0] cs_exp(input m);
        cs_exp = {2'b00, gpb, gpa, m, 3'b000};
    endfunction
    // Counts a comparison and reports a mismatch.
    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        begin
            $display("checks %0d, errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    // Resets with the given straps held steady.
    task do_reset(input [2:0] st);
        begin
            nrst = 1'b0;
            strap = st;
            repeat (6) @(posedge clk);
            #1;
            nrst = 1'b1;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    // One bus transaction; a0 is the address acknowledge, low when taken.
    task access(input [6:0] addr, input [7:0] ix, input rd, input [7:0] wd, output a0, output [7:0] rv);
        reg a1;
        begin
            i_host.edge_cond(1'b0, 1'b1);
            i_host.xfer({addr, 1'b0}, 1'b1, q, a0);
            if (!a0) begin
                i_host.xfer(ix, 1'b1, q, a1);
                if (rd) begin
                    i_host.edge_cond(1'b0, 1'b1);
                    i_host.xfer({addr, 1'b1}, 1'b1, q, a1);
                    i_host.xfer(8'hff, 1'b1, rv, a1);
                end else begin
                    i_host.xfer(wd, 1'b1, q, a1);
                end
            end
            i_host.edge_cond(1'b1, 1'b0);
        end
    endtask
    // Cuts a hang short.
    initial begin
        #6000000;
        n_errors = n_errors + 1;
        print_verdict;
    end
    // Main sequence.
    initial begin
        q = $urandom(32'hd801);
        for (s = 0; s < 8; s = s + 1) begin
            do_reset(s[2:0]);
            q = $urandom;
            gpa = q[0];
            gpb = q[1];
            check({7'h0, int_n_oe}, 8'h00);
            access(bad, `SSI_IDX_COMMON, 1'b1, 8'h00, ack, q);
            check({7'h0, ack}, 8'h01);
            access(dev, `SSI_IDX_COMMON, 1'b1, 8'h00, ack, q);
            check({7'h0, ack}, 8'h00);
            check(q, cs_exp(1'b0));
        end
        $display("strap and input test done");
        do_reset(3'h5);
        for (s = 0; s < 6; s = s + 1) begin
            oh = 3'h1 << (s % 3);
            idx = (s < 3) ? `SSI_IDX_STAT_A : `SSI_IDX_STAT_B;
            trip_a = (s < 3) ? oh : 3'h0;
            trip_b = (s < 3) ? 3'h0 : oh;
            @(posedge clk);
            #1;
            trip_a = 3'h0;
            trip_b = 3'h0;
            @(posedge clk);
            #1;
            check({7'h0, int_n_oe}, 8'h01);
            access(dev, idx, 1'b0, {5'h0, oh[1:0], oh[2]}, ack, q);
            access(dev, idx, 1'b1, 8'h00, ack, q);
            check(q, {5'h0, oh});
            check({7'h0, int_n_oe}, 8'h01);
            access(dev, idx, 1'b0, {5'h0, oh}, ack, q);
            check({7'h0, int_n_oe}, 8'h00);
        end
        $display("trip and echo clear test done");
        access(dev, `SSI_IDX_COMMON, 1'b0, 8'h08, ack, q);
        access(dev, `SSI_IDX_COMMON, 1'b1, 8'h00, ack, q);
        check(q, cs_exp(1'b1));
        trip_b = 3'h4;
        repeat (3) @(posedge clk);
        #1;
        check({7'h0, int_n_oe}, 8'h00);
        access(dev, `SSI_IDX_STAT_B, 1'b0, 8'h04, ack, q);
        access(dev, `SSI_IDX_STAT_B, 1'b1, 8'h00, ack, q);
        check(q, 8'h04);
        access(dev, `SSI_IDX_COMMON, 1'b0, 8'h00, ack, q);
        check({7'h0, int_n_oe}, 8'h01);
        trip_b = 3'h0;
        access(dev, `SSI_IDX_STAT_B, 1'b0, 8'h04, ack, q);
        check({7'h0, int_n_oe}, 8'h00);
        access(dev, 8'h05, 1'b0, 8'hff, ack, q);
        access(dev, 8'h05, 1'b1, 8'h00, ack, q);
        check(q, 8'h00);
        $display("mask and unmapped test done");
        print_verdict;
    end
endmodule
